/* csdc_defines.vh */
// register offsets, field positions and constants of the clock switch block
`ifndef CSDC_DEFINES_VH
`define CSDC_DEFINES_VH

// register byte offsets
`define CSDC_OSC_CTRL_ADDR   12'h000
`define CSDC_CLK_DIV_ADDR    12'h004
`define CSDC_UNLOCK_ADDR     12'h008
`define CSDC_IRQ_STAT_ADDR   12'h00C
`define CSDC_IRQ_MASK_ADDR   12'h010

// oscillator_control fields
`define CSDC_OSC_SWREQ_BIT   0
`define CSDC_OSC_CFAIL_BIT   3
`define CSDC_OSC_CUR_LSB     12
`define CSDC_OSC_NEXT_LSB    8
`define CSDC_OSC_RESET       16'h0000

// clock_divisor_reg fields
`define CSDC_DIV_RATIO_LSB   12
`define CSDC_DIV_ON_BIT      11
`define CSDC_DIV_ROI_BIT     15
`define CSDC_DIV_RESET       16'h0000

// unlock keys, written in order to the unlock register
`define CSDC_KEY_FIRST       16'h0057
`define CSDC_KEY_SECOND      16'h00AA

// interrupt status bits
`define CSDC_IRQ_FAIL_BIT    0
`define CSDC_IRQ_SWDONE_BIT  1
`define CSDC_IRQ_REJECT_BIT  2

// source codes
`define CSDC_SRC_FRC         3'h0
`define CSDC_SRC_INTERNAL_RC_MULTIPLIED      3'h1
`define CSDC_SRC_PRIPLL      3'h3

// switch settle time in ns and its cycle count at 125 MHz
`define CSDC_SWITCH_NS       64
`define CSDC_CLK_NS          8
`define CSDC_SWITCH_CYC      ((`CSDC_SWITCH_NS + `CSDC_CLK_NS - 1) / `CSDC_CLK_NS)

`endif

/* csdc_doze_div.v */
// cpu clock enable divider for doze mode
`timescale 1ns/10ps
module csdc_doze_div
#(
  parameter RATIO_W = 3
)
(
  input  wire               i_core_clk,
  input  wire               i_rst_n,
  input  wire               i_div_on,
  input  wire [RATIO_W-1:0] i_ratio,
  output reg                o_cpu_tick
);

  reg  [6:0] count;
  wire [6:0] limit;

  // divide by 2**ratio, ratio 0 gives a tick every cycle
  assign limit = (7'h01 << i_ratio) - 7'h01;

  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      count      <= 7'h00;
      o_cpu_tick <= 1'b1;
    end
    else if (!i_div_on)
    begin
      count      <= 7'h00;
      o_cpu_tick <= 1'b1;
    end
    else if (count >= limit)
    begin
      count      <= 7'h00;
      o_cpu_tick <= 1'b1;
    end
    else
    begin
      count      <= count + 7'h01;
      o_cpu_tick <= 1'b0;
    end
  end

endmodule

/* csdc_clock_switch.v */
// clock switch, fail flag and doze control with an apb register slave
// How it works
// - monitor loss sets the clock fail flag
// - writing one to fail flag raises trap
// - switch request starts switch to next source
// - switch request clears when switch completes
// - oscillator control writes need unlock first
// - ratio writes ignored while divide enabled
// - divide enable ignored when ratio is zero
// - interrupt clears divide enable when recover set
// - cpu clock slowed only in doze
// - unimplemented control bits read as zero
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "csdc_defines.vh"
module csdc_clock_switch
#(
  parameter SWITCH_CYC = `CSDC_SWITCH_CYC
)
(
  input  wire        i_core_clk,
  input  wire        i_reset_n,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output wire        o_pready,
  output reg  [31:0] o_prdata,
  output wire        o_pslverr,
  input  wire        i_clock_lost,
  input  wire        i_cpu_irq,
  output reg  [2:0]  o_source_select,
  output reg         o_fail_trap,
  output wire        o_cpu_tick,
  output wire        o_periph_tick,
  output wire        o_irq
);

  // --------------------------------------------------------------
  // reset and input synchronisers
  // --------------------------------------------------------------
  reg        rst_meta;
  reg        rst_n;
  reg  [1:0] lost_sync;
  reg  [1:0] irq_sync;

  always @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  always @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lost_sync <= 2'h0;
      irq_sync  <= 2'h0;
    end
    else
    begin
      lost_sync <= {lost_sync[0], i_clock_lost};
      irq_sync  <= {irq_sync[0], i_cpu_irq};
    end
  end

  // --------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------
  wire wr_en;
  wire rd_en;
  wire hit_osc;
  wire hit_div;
  wire hit_key;
  wire hit_stat;
  wire hit_mask;
  wire mapped;

  assign wr_en    = i_psel & i_penable & i_pwrite;
  assign rd_en    = i_psel & ~i_pwrite;
  assign hit_osc  = (i_paddr == `CSDC_OSC_CTRL_ADDR);
  assign hit_div  = (i_paddr == `CSDC_CLK_DIV_ADDR);
  assign hit_key  = (i_paddr == `CSDC_UNLOCK_ADDR);
  assign hit_stat = (i_paddr == `CSDC_IRQ_STAT_ADDR);
  assign hit_mask = (i_paddr == `CSDC_IRQ_MASK_ADDR);
  assign mapped   = hit_osc | hit_div | hit_key | hit_stat | hit_mask;
  assign o_pready          = 1'b1;
  assign o_pslverr         = i_psel & i_penable & ~mapped;

  // --------------------------------------------------------------
  // unlock sequence
  // --------------------------------------------------------------
  localparam [2:0] LK_IDLE = 3'h1;
  localparam [2:0] LK_HALF = 3'h2;
  localparam [2:0] LK_OPEN = 3'h4;

  reg  [2:0] lock_state;
  reg  [2:0] next_lock_state;
  wire       osc_wr_ok;

  assign osc_wr_ok = wr_en & hit_osc & lock_state[2];

  always @*
  begin
    next_lock_state = lock_state;
    case (lock_state)
      LK_IDLE:
        if (wr_en && hit_key && i_pwdata[15:0] == `CSDC_KEY_FIRST)
          next_lock_state = LK_HALF;
      LK_HALF:
        if (wr_en && hit_key && i_pwdata[15:0] == `CSDC_KEY_SECOND)
          next_lock_state = LK_OPEN;
        else if (wr_en)
          next_lock_state = LK_IDLE;
      LK_OPEN:
        if (wr_en)
          next_lock_state = LK_IDLE;
      default:
        next_lock_state = LK_IDLE;
    endcase
  end

  // --------------------------------------------------------------
  // oscillator control and switch engine
  // --------------------------------------------------------------
  reg        clock_fail_flag;
  reg        switch_request;
  reg  [2:0] next_source_select;
  reg  [7:0] settle;
  reg        switch_done_ev;
  reg        reject_ev;
  wire       bad_pair;
  wire [2:0] req_src;

  assign req_src  = i_pwdata[`CSDC_OSC_NEXT_LSB+2:`CSDC_OSC_NEXT_LSB];
  // multiplied sources may not hand over to each other directly
  assign bad_pair = ((o_source_select == `CSDC_SRC_PRIPLL) &&
                     (req_src == `CSDC_SRC_INTERNAL_RC_MULTIPLIED)) ||
                    ((o_source_select == `CSDC_SRC_INTERNAL_RC_MULTIPLIED) &&
                     (req_src == `CSDC_SRC_PRIPLL));

  always @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lock_state         <= LK_IDLE;
      clock_fail_flag    <= 1'b0;
      switch_request     <= 1'b0;
      next_source_select <= `CSDC_SRC_FRC;
      o_source_select    <= `CSDC_SRC_FRC;
      settle             <= 8'h00;
      o_fail_trap        <= 1'b0;
      switch_done_ev     <= 1'b0;
      reject_ev          <= 1'b0;
    end
    else
    begin
      lock_state     <= next_lock_state;
      switch_done_ev <= 1'b0;
      reject_ev      <= 1'b0;
      o_fail_trap    <= 1'b0;
      // fail flag: detection wins over a software clear
      if (lost_sync[1])
      begin
        clock_fail_flag <= 1'b1;
        o_fail_trap     <= ~clock_fail_flag;
      end
      else if (osc_wr_ok)
      begin
        clock_fail_flag <= i_pwdata[`CSDC_OSC_CFAIL_BIT];
        o_fail_trap     <= i_pwdata[`CSDC_OSC_CFAIL_BIT];
      end
      if (switch_request)
      begin
        if (settle == 8'h00)
        begin
          o_source_select <= next_source_select;
          switch_request  <= 1'b0;
          switch_done_ev  <= 1'b1;
        end
        else
          settle <= settle - 8'h01;
      end
      else if (osc_wr_ok)
      begin
        next_source_select <= req_src;
        if (i_pwdata[`CSDC_OSC_SWREQ_BIT])
        begin
          if (bad_pair)
            reject_ev <= 1'b1;
          else
          begin
            switch_request <= 1'b1;
            settle         <= SWITCH_CYC[7:0];
          end
        end
      end
    end
  end

  // --------------------------------------------------------------
  // clock divisor register
  // --------------------------------------------------------------
  reg        recover_on_irq;
  reg        cpu_divide_on;
  reg  [2:0] doze_ratio;
  reg        irq_prev;
  wire       irq_rise;
  wire [2:0] new_ratio;

  assign irq_rise  = irq_sync[1] & ~irq_prev;
  assign new_ratio = (wr_en && hit_div && !cpu_divide_on) ?
                     i_pwdata[`CSDC_DIV_RATIO_LSB+2:`CSDC_DIV_RATIO_LSB] :
                     doze_ratio;

  always @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      recover_on_irq <= 1'b0;
      cpu_divide_on  <= 1'b0;
      doze_ratio     <= 3'h0;
      irq_prev       <= 1'b0;
    end
    else
    begin
      irq_prev <= irq_sync[1];
      if (wr_en && hit_div)
      begin
        recover_on_irq <= i_pwdata[`CSDC_DIV_ROI_BIT];
        doze_ratio     <= new_ratio;
      end
      if (recover_on_irq && irq_rise)
        cpu_divide_on <= 1'b0;
      else if (wr_en && hit_div)
        cpu_divide_on <= i_pwdata[`CSDC_DIV_ON_BIT] &
                         (new_ratio != 3'h0);
    end
  end

  // --------------------------------------------------------------
  // doze divider
  // --------------------------------------------------------------
  csdc_doze_div
  #(
    .RATIO_W (3)
  )
  u_doze
  (
    .i_core_clk (i_core_clk),
    .i_rst_n    (rst_n),
    .i_div_on   (cpu_divide_on),
    .i_ratio    (doze_ratio),
    .o_cpu_tick (o_cpu_tick)
  );

  assign o_periph_tick = 1'b1;

  // --------------------------------------------------------------
  // interrupt status and mask
  // --------------------------------------------------------------
  reg  [2:0] irq_stat;
  reg  [2:0] irq_mask;
  wire [2:0] irq_set;

  assign irq_set = {reject_ev, switch_done_ev, o_fail_trap};
  assign o_irq   = |(irq_stat & irq_mask);

  always @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_stat <= 3'h0;
      irq_mask <= 3'h0;
    end
    else
    begin
      if (wr_en && hit_mask)
        irq_mask <= i_pwdata[2:0];
      if (wr_en && hit_stat)
        irq_stat <= (irq_stat & ~i_pwdata[2:0]) | irq_set;
      else
        irq_stat <= irq_stat | irq_set;
    end
  end

  // --------------------------------------------------------------
  // read data
  // --------------------------------------------------------------
  always @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_prdata <= 32'h0000_0000;
    else if (rd_en && !i_penable)
    begin
      o_prdata <= 32'h0000_0000;
      if (hit_osc)
        o_prdata[15:0] <= {1'b0, o_source_select, 1'b0, next_source_select,
                           4'h0, clock_fail_flag, 2'h0,
                           switch_request};
      else if (hit_div)
        o_prdata[15:0] <= {recover_on_irq, doze_ratio, cpu_divide_on,
                           11'h000};
      else if (hit_key)
        o_prdata[2:0] <= lock_state;
      else if (hit_stat)
        o_prdata[2:0] <= irq_stat;
      else if (hit_mask)
        o_prdata[2:0] <= irq_mask;
    end
  end

endmodule

/* csdc_clock_switch_asserts.sv */
// assertions on the ports of the clock switch block
`timescale 1ns/10ps
module csdc_clock_switch_chk
#(
  parameter SWITCH_CYC = 8
)
(
  input wire        i_core_clk,
  input wire        i_reset_n,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire        o_pslverr,
  input wire [2:0]  o_source_select,
  input wire        o_fail_trap,
  input wire        o_periph_tick,
  input wire        o_cpu_tick
);
  localparam int LIM = SWITCH_CYC + 4;
  logic       wr0;
  logic       fb;
  logic [2:0] k2h;
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);
  // ----
  // unlock history, forbidden pair
  // ----
  assign wr0 = i_psel && i_penable && i_pwrite && i_paddr == 12'h000;
  assign fb = (o_source_select == 3'h1 && i_pwdata[10:8] == 3'h3)
    || (o_source_select == 3'h3 && i_pwdata[10:8] == 3'h1);
  always @(posedge i_core_clk or negedge i_reset_n)
    if (!i_reset_n)
      k2h <= 3'h0;
    else
      k2h <= {k2h[1:0], i_psel && i_penable && i_pwrite
        && i_paddr == 12'h008 && i_pwdata[15:0] == 16'h00AA};
  sequence s_key(d);
    i_psel && i_penable && i_pwrite && i_paddr == 12'h008
      && i_pwdata[15:0] == d;
  endsequence
  sequence s_unl;
    s_key(16'h0057) ##3 s_key(16'h00AA) ##3 wr0;
  endsequence
  property p_per;
    o_periph_tick;
  endproperty
  a_per: assert property (p_per) else $error("periph tick low");
  property p_doff;
    i_psel && i_penable && i_pwrite && i_paddr == 12'h004 && !i_pwdata[11]
      |=> ##1 o_cpu_tick;
  endproperty
  a_doff: assert property (p_doff) else $error("cpu tick slow");
  property p_rsv;
    i_psel && i_penable && !i_pwrite && i_paddr == 12'h000
      |-> o_prdata[4] == 1'b0 && o_prdata[2:1] == 2'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_one;
    o_fail_trap |=> !o_fail_trap;
  endproperty
  a_one: assert property (p_one) else $error("trap too long");
  property p_trp;
    s_unl ##0 i_pwdata[3] |-> ##[1:2] o_fail_trap;
  endproperty
  a_trp: assert property (p_trp) else $error("no trap");
  property p_sw;
    logic [2:0] n;
    (s_unl ##0 (i_pwdata[0] && !fb, n = i_pwdata[10:8]))
      |-> ##[1:LIM] o_source_select == n;
  endproperty
  a_sw: assert property (p_sw) else $error("switch missing");
  property p_rej;
    s_unl ##0 (i_pwdata[0] && fb) |=> $stable(o_source_select) [*8];
  endproperty
  a_rej: assert property (p_rej) else $error("bad switch taken");
  property p_lck;
    wr0 && i_pwdata[0] && !k2h[2] |=> $stable(o_source_select) [*8];
  endproperty
  a_lck: assert property (p_lck) else $error("locked write taken");
  property p_err;
    i_psel && i_penable && i_paddr > 12'h010 |-> o_pslverr;
  endproperty
  a_err: assert property (p_err) else $error("no slave error");
endmodule

bind csdc_clock_switch csdc_clock_switch_chk #(.SWITCH_CYC(SWITCH_CYC))
  u_chk (.*);

/* csdc_clock_switch_bench.sv */
// self-checking bench of the clock switch block
`timescale 1ns/10ps
module csdc_clock_switch_bench;
  logic        i_core_clk = 1'h0;
  logic        i_reset_n = 1'h0;
  logic        i_psel = 1'h0;
  logic        i_penable = 1'h0;
  logic        i_pwrite = 1'h0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0;
  logic        i_clock_lost = 1'h0;
  logic        i_cpu_irq = 1'h0;
  wire         o_pready, o_pslverr, o_fail_trap;
  wire         o_cpu_tick, o_periph_tick, o_irq;
  wire  [31:0] o_prdata;
  wire  [2:0]  o_source_select;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          nt = 0;
  int          ntrap = 0;
  logic [31:0] seed = 32'h794E0B55;
  logic [31:0] q[$];
  logic [2:0]  r;
  csdc_clock_switch #(.SWITCH_CYC(2)) u_csdc_clock_switch (.*);
  always #4 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk)
    if (o_cpu_tick === 1'h1)
      nt <= nt + 1;
  always @(posedge i_core_clk)
    if (o_fail_trap === 1'h1)
      ntrap <= ntrap + 1;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  // ----
  // apb master
  // ----
  task automatic xf(logic [11:0] a, logic w, logic [31:0] d);
    @(posedge i_core_clk);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1'h1;
    @(posedge i_core_clk);
    while (o_pready !== 1'h1)
      @(posedge i_core_clk);
    i_psel <= 1'h0;
    i_penable <= 1'h0;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e);
    q.push_back(e);
    xf(a, 1'h0, 32'h0);
  endtask
  task automatic uw(logic [31:0] d);
    xf(12'h008, 1'h1, 32'h57);
    xf(12'h008, 1'h1, 32'hAA);
    xf(12'h000, 1'h1, d);
  endtask
  task automatic ticks(int n, int e);
    int s;
    s = nt;
    repeat (n) @(posedge i_core_clk);
    chk("ticks", nt - s, e);
  endtask
  always @(posedge i_core_clk)
    if (i_psel && i_penable && !i_pwrite && o_pready)
      if (i_paddr > 12'h010)
        chk("slverr", o_pslverr, 32'h1);
      else
        chk("rdata", o_prdata, q.pop_front());
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (4000) @(posedge i_core_clk);
    n_mismatch++;
    print_verdict;
  end
  // ----
  // scenarios
  // ----
  initial
  begin
    repeat (2) @(posedge i_core_clk);
    i_reset_n <= 1'h1;
    repeat (3) @(posedge i_core_clk);
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h0);
    rd(12'h00C, 32'h0);
    xf(12'h014, 1'h0, 32'h0);
    xf(12'h000, 1'h1, 32'h101);
    rd(12'h000, 32'h0);
    uw(32'h101);
    rd(12'h000, 32'h101);
    repeat (8) @(posedge i_core_clk);
    rd(12'h000, 32'h1100);
    uw(32'h301);
    rd(12'h00C, 32'h6);
    uw(32'h001);
    repeat (8) @(posedge i_core_clk);
    uw(32'h301);
    repeat (8) @(posedge i_core_clk);
    chk("src", o_source_select, 32'h3);
    chk("irq", o_irq, 32'h0);
    xf(12'h010, 1'h1, (xs() & 32'h7) | 32'h2);
    @(negedge i_core_clk) chk("irq", o_irq, 32'h1);
    xf(12'h00C, 1'h1, 32'h7);
    rd(12'h00C, 32'h0);
    chk("irq", o_irq, 32'h0);
    uw(32'h308);
    rd(12'h000, 32'h3308);
    chk("trap", ntrap, 32'h1);
    uw(32'h300);
    rd(12'h000, 32'h3300);
    xf(12'h00C, 1'h1, 32'h7);
    i_clock_lost <= 1'h1;
    repeat (6) @(posedge i_core_clk);
    rd(12'h000, 32'h3308);
    rd(12'h00C, 32'h1);
    chk("trap", ntrap, 32'h2);
    i_clock_lost <= 1'h0;
    xf(12'h004, 1'h1, 32'h800);
    rd(12'h004, 32'h0);
    r = xs() % 7 + 1;
    xf(12'h004, 1'h1, {r, 12'h000});
    xf(12'h004, 1'h1, {r, 12'h800});
    rd(12'h004, {r, 12'h800});
    ticks(8 << r, 8);
    xf(12'h004, 1'h1, {~r, 12'h800});
    rd(12'h004, {r, 12'h800});
    xf(12'h004, 1'h1, {1'h1, r, 12'h800});
    i_cpu_irq <= 1'h1;
    repeat (6) @(posedge i_core_clk);
    rd(12'h004, {1'h1, r, 12'h000});
    ticks(16, 16);
    chk("periph", o_periph_tick, 32'h1);
    print_verdict;
  end
endmodule
